//--- common/iex_pkg.sv
// package: constants, opcodes and carriers for the instruction execution subset
`default_nettype none
package iex_pkg;
	localparam int          PC_W        = 13;
	localparam int          IW_W        = 14;
	localparam int          FA_W        = 7;
	localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
	localparam logic [12:0] PC_RESET    = 13'h0000;
	localparam logic [7:0]  DATA_RESET  = 8'h00;
	localparam logic [7:0]  WD_CNT_RESET = 8'h00;
	localparam logic [7:0]  PRE_RESET   = 8'h00;
	// opcode patterns of the 14-bit word
	localparam logic [2:0]  OP_CALL     = 3'h4;
	localparam logic [13:0] OP_KICK     = 14'h0064;
	localparam logic [13:0] OP_ACLR     = 14'h0100;
	localparam logic [6:0]  OP_FCLR     = 7'h03;
	localparam logic [5:0]  OP_FINV     = 6'h09;
	localparam logic [5:0]  OP_FDEC     = 6'h03;
	localparam int          DEST_BIT    = 7;
	localparam int          LATCH_LO    = 3;
	localparam int          LATCH_HI    = 4;

	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} iex_fwr_t;

	typedef struct packed {
		logic expiry;
		logic sleep_entry;
		logic null_res;
	} iex_stat_t;

	// expiry and sleep-entry come up set, the null flag clear
	localparam iex_stat_t   STAT_RESET  = '{expiry: 1'b1, sleep_entry: 1'b1, null_res: 1'b0};
endpackage
`default_nettype wire

//--- rtl/iex_core.sv
// execution core for call, watchdog kick, clear, complement, decrement, wake vector
`timescale 1ns/10ps
`default_nettype none
module iex_core #(
	parameter int STACK_D = 8
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic [13:0]          instr_i,
	input  wire logic                 instr_valid_i,
	input  wire logic [7:0]           file_rdata_i,
	input  wire logic [7:0]           pc_upper_latch_i,
	input  wire logic                 global_irq_enable_i,
	input  wire logic                 sleeping_i,
	input  wire logic                 irq_wake_i,
	input  wire logic                 wdt_wake_i,
	output logic [12:0]               pc_o,
	output logic [12:0]               stack_top_o,
	output logic [7:0]                accum_o,
	output iex_pkg::iex_fwr_t         file_wr_o,
	output iex_pkg::iex_stat_t        status_o,
	output logic [7:0]                watchdog_counter_o,
	output logic [7:0]                wdt_prescaler_o,
	output logic                      busy_o,
	output logic                      wake_irq_flag_o,
	output logic                      wake_wdt_flag_o
);
	////////////////////////////////////////////////////////////////////////
	// register state, one always_comb and one always_ff per register group; the stack body has its own always_ff
	localparam int SP_W = $clog2(STACK_D);

	typedef enum logic {IEX_RUN, IEX_SECOND} iex_state_t;
	iex_state_t         state;
	iex_state_t         next_state;
	logic               busy;
	logic               next_busy;

	logic [12:0]        pc;
	logic [12:0]        next_pc;
	logic [12:0]        stk_top;
	logic [12:0]        next_stk_top;
	logic [SP_W-1:0]    sp;
	logic [SP_W-1:0]    next_sp;
	logic               push;
	// return addresses; overflow wraps and silently overwrites the oldest entry
	logic [12:0]        stack [STACK_D];

	logic [7:0]         accum;
	logic [7:0]         next_accum;
	iex_pkg::iex_fwr_t  fwr;
	iex_pkg::iex_fwr_t  next_fwr;
	iex_pkg::iex_stat_t stat;
	iex_pkg::iex_stat_t next_stat;

	logic [7:0]         wd_cnt;
	logic [7:0]         next_wd_cnt;
	logic [7:0]         wd_pre;
	logic [7:0]         next_wd_pre;

	logic               wirq;
	logic               next_wirq;
	logic               wwd;
	logic               next_wwd;

	// decoded view of the word presented this cycle
	logic               take;
	logic               is_call;
	logic               is_kick;
	logic               is_aclr;
	logic               is_fclr;
	logic               is_finv;
	logic               is_fdec;
	logic               is_arith;
	logic               dest_file;
	logic [7:0]         result;
	logic               res_zero;
	logic [12:0]        pc_inc;
	logic               wake_vec;

	////////////////////////////////////////////////////////////////////////
	// a word counts only while awake and outside the second cycle of a call
	always_comb begin
		take      = 1'b0;
		is_call   = 1'b0;
		is_kick   = 1'b0;
		is_aclr   = 1'b0;
		is_fclr   = 1'b0;
		is_finv   = 1'b0;
		is_fdec   = 1'b0;
		is_arith  = 1'b0;
		dest_file = 1'b0;
		result    = iex_pkg::DATA_RESET;
		res_zero  = 1'b0;
		pc_inc    = pc;
		wake_vec  = 1'b0;
		if (state == IEX_RUN && !sleeping_i && instr_valid_i) begin
			take = 1'b1;
		end
		if (take) begin
			if (instr_i[13:11] == iex_pkg::OP_CALL) begin
				is_call = 1'b1;
			end else if (instr_i == iex_pkg::OP_KICK) begin
				is_kick = 1'b1;
			end else if (instr_i == iex_pkg::OP_ACLR) begin
				is_aclr = 1'b1;
			end else if (instr_i[13:7] == iex_pkg::OP_FCLR) begin
				is_fclr = 1'b1;
			end else if (instr_i[13:8] == iex_pkg::OP_FINV) begin
				is_finv = 1'b1;
			end else if (instr_i[13:8] == iex_pkg::OP_FDEC) begin
				is_fdec = 1'b1;
			end
		end
		is_arith  = is_finv | is_fdec;
		dest_file = instr_i[iex_pkg::DEST_BIT];
		pc_inc    = pc + 13'h0001;
		wake_vec  = (state == IEX_RUN) && sleeping_i && irq_wake_i && global_irq_enable_i;
		case ({is_finv, is_fdec})
		2'b10: result = ~file_rdata_i;
		2'b01: result = file_rdata_i - 8'h01;
		default: result = iex_pkg::DATA_RESET;
		endcase
		res_zero = (result == 8'h00);
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing: a call holds the core for one dead cycle
	always_comb begin
		next_state = state;
		case (state)
		IEX_RUN: begin
			if (is_call) begin
				next_state = IEX_SECOND;
			end
		end
		IEX_SECOND: begin
			// the word fetched here is discarded
			next_state = IEX_RUN;
		end
		default: begin
			next_state = IEX_RUN;
		end
		endcase
		next_busy = (next_state == IEX_SECOND);
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= IEX_RUN;
			busy  <= 1'b0;
		end else begin
			state <= next_state;
			busy  <= next_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter and return stack
	always_comb begin
		next_pc      = pc;
		next_sp      = sp;
		next_stk_top = stk_top;
		push         = 1'b0;
		if (wake_vec) begin
			next_pc = iex_pkg::IRQ_VECTOR;
		end else if (is_call) begin
			push         = 1'b1;
			next_stk_top = pc_inc;
			next_sp      = sp + {{(SP_W-1){1'b0}}, 1'b1};
			next_pc      = {pc_upper_latch_i[iex_pkg::LATCH_HI:iex_pkg::LATCH_LO],
				instr_i[10:0]};
		end else if (take) begin
			next_pc = pc_inc;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pc      <= iex_pkg::PC_RESET;
			sp      <= '0;
			stk_top <= iex_pkg::PC_RESET;
		end else begin
			pc      <= next_pc;
			sp      <= next_sp;
			stk_top <= next_stk_top;
		end
	end

	// stack body has no reset; only pushed slots hold meaning
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			stack[sp] <= pc_inc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulator, file write port and status
	always_comb begin
		next_accum = accum;
		next_fwr   = '{we: 1'b0, addr: instr_i[6:0], data: iex_pkg::DATA_RESET};
		next_stat  = stat;
		if (is_kick) begin
			next_stat.expiry      = 1'b1;
			next_stat.sleep_entry = 1'b1;
		end
		if (is_aclr) begin
			next_accum         = iex_pkg::DATA_RESET;
			next_stat.null_res = 1'b1;
		end
		if (is_fclr) begin
			next_fwr.we        = 1'b1;
			next_fwr.data      = iex_pkg::DATA_RESET;
			next_stat.null_res = 1'b1;
		end
		if (is_arith) begin
			next_stat.null_res = res_zero;
			if (dest_file) begin
				next_fwr.we   = 1'b1;
				next_fwr.data = result;
			end else begin
				next_accum = result;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			accum <= iex_pkg::DATA_RESET;
			fwr   <= '0;
			stat  <= iex_pkg::STAT_RESET;
		end else begin
			accum <= next_accum;
			fwr   <= next_fwr;
			stat  <= next_stat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog: the prescaler runs every cycle, the counter steps on its wrap
	always_comb begin
		next_wd_pre = wd_pre + 8'h01;
		next_wd_cnt = wd_cnt;
		if (&wd_pre) begin
			next_wd_cnt = wd_cnt + 8'h01;
		end
		if (is_kick) begin
			next_wd_cnt = iex_pkg::WD_CNT_RESET;
			next_wd_pre = iex_pkg::PRE_RESET;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd_cnt <= iex_pkg::WD_CNT_RESET;
			wd_pre <= iex_pkg::PRE_RESET;
		end else begin
			wd_cnt <= next_wd_cnt;
			wd_pre <= next_wd_pre;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// wake causes are sticky until reset, so software can always see why
	always_comb begin
		next_wirq = wirq;
		next_wwd  = wwd;
		if (sleeping_i) begin
			next_wirq = wirq | irq_wake_i;
			next_wwd  = wwd | wdt_wake_i;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wirq <= 1'b0;
			wwd  <= 1'b0;
		end else begin
			wirq <= next_wirq;
			wwd  <= next_wwd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// every output is a register
	assign pc_o               = pc;
	assign stack_top_o        = stk_top;
	assign accum_o            = accum;
	assign file_wr_o          = fwr;
	assign status_o           = stat;
	assign watchdog_counter_o = wd_cnt;
	assign wdt_prescaler_o    = wd_pre;
	assign busy_o             = busy;
	assign wake_irq_flag_o    = wirq;
	assign wake_wdt_flag_o    = wwd;
endmodule
`default_nettype wire

//--- tb/iex_chk_sva.sv
// checker: timing relations at the ports of the execution core
`timescale 1ns/10ps
`default_nettype none
module iex_chk (
	input wire logic sys_clk_i, nrst_i, instr_valid_i, global_irq_enable_i, sleeping_i,
	input wire logic irq_wake_i, wdt_wake_i, busy_o, wake_irq_flag_o, wake_wdt_flag_o,
	input wire logic [13:0] instr_i,
	input wire logic [7:0] file_rdata_i, pc_upper_latch_i, accum_o,
	input wire logic [7:0] watchdog_counter_o, wdt_prescaler_o,
	input wire logic [12:0] pc_o, stack_top_o,
	input wire iex_pkg::iex_fwr_t file_wr_o,
	input wire iex_pkg::iex_stat_t status_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	wire tk = instr_valid_i && !busy_o && !sleeping_i;
	wire call = tk && instr_i[13:11] == iex_pkg::OP_CALL;
	wire dec = tk && instr_i[13:8] == iex_pkg::OP_FDEC && !instr_i[7];
	wire inv = tk && instr_i[13:8] == iex_pkg::OP_FINV && instr_i[7];
	a_call_target: assert property (call |=>
		pc_o == {$past(pc_upper_latch_i[4:3]), $past(instr_i[10:0])}) else $error("call target");
	a_call_push: assert property (call |=>
		stack_top_o == $past(pc_o) + 13'h1) else $error("return address");
	a_call_busy: assert property (call |=> busy_o ##1 !busy_o) else $error("call length");
	a_kick_clear: assert property (tk && instr_i == iex_pkg::OP_KICK |=>
		watchdog_counter_o == 8'h00 && wdt_prescaler_o == 8'h00 && status_o.expiry
		&& status_o.sleep_entry && $stable(status_o.null_res)) else $error("kick");
	a_acc_clear: assert property (tk && instr_i == iex_pkg::OP_ACLR |=>
		accum_o == 8'h00 && status_o.null_res) else $error("accum clear");
	a_file_clear: assert property (tk && instr_i[13:7] == iex_pkg::OP_FCLR |=>
		file_wr_o.we && file_wr_o.data == 8'h00 && status_o.null_res) else $error("file clear");
	a_inv_back: assert property (inv |=> file_wr_o.we &&
		file_wr_o.data == ~$past(file_rdata_i) && file_wr_o.addr == $past(instr_i[6:0]))
		else $error("invert to file");
	a_dec_accum: assert property (dec |=> !file_wr_o.we &&
		accum_o == $past(file_rdata_i) - 8'h01 && status_o.null_res == (accum_o == 8'h00))
		else $error("decrement to accum");
	a_wake_vector: assert property (sleeping_i && irq_wake_i && global_irq_enable_i |->
		##[1:2] pc_o == iex_pkg::IRQ_VECTOR) else $error("wake vector");
	a_wake_cause: assert property (sleeping_i && (irq_wake_i || wdt_wake_i) |->
		##[1:2] (wake_irq_flag_o || wake_wdt_flag_o)) else $error("wake cause");
	c_call: cover property (call);
	c_dec: cover property (dec);
	c_wake: cover property (sleeping_i && irq_wake_i && global_irq_enable_i);
endmodule
bind iex_core iex_chk iex_chk_inst (.*);
`default_nettype wire

//--- tb/iex_fmem.sv
// partner model: data memory answering the addressed file register
`timescale 1ns/10ps
`default_nettype none
module iex_fmem (
	input  wire logic              sys_clk_i,
	input  wire logic [13:0]       instr_i,
	input  wire iex_pkg::iex_fwr_t file_wr_o,
	output logic [7:0]             file_rdata_i
);
	logic [7:0] mem [128];
	// read is combinational so the core sees the operand in the issue cycle
	assign file_rdata_i = mem[instr_i[6:0]];
	// plain always: the bench preloads this array before the first edge
	always @(posedge sys_clk_i) begin
		if (file_wr_o.we) begin
			mem[file_wr_o.addr] <= file_wr_o.data;
		end
	end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the execution core
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic sys_clk_i, nrst_i, instr_valid_i, global_irq_enable_i, sleeping_i, irq_wake_i;
	logic wdt_wake_i, busy_o, wake_irq_flag_o, wake_wdt_flag_o;
	logic [13:0] instr_i;
	logic [7:0] file_rdata_i, pc_upper_latch_i, accum_o, watchdog_counter_o, wdt_prescaler_o;
	logic [12:0] pc_o, stack_top_o;
	iex_pkg::iex_fwr_t file_wr_o;
	iex_pkg::iex_stat_t status_o;
	logic [31:0] s = 32'h10;
	logic [25:0] q [$];
	logic [25:0] e;
	int n_mismatch = 0;
	int checks = 0;
	iex_core iex_core_inst (.*);
	iex_fmem iex_fmem_inst (.*);
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [7:0] xs();
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s[7:0];
	endfunction
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
		checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, x, g);
		end
	endtask
	// one idle cycle between issues also covers the dead cycle after a call
	task automatic go(input logic [13:0] w, input logic [25:0] x);
		@(posedge sys_clk_i);
		instr_i <= w;
		instr_valid_i <= 1'b1;
		@(posedge sys_clk_i);
		instr_valid_i <= 1'b0;
		q.push_back(x);
	endtask
	task automatic close_out();
		if (q.size() != 0) n_mismatch++;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(negedge sys_clk_i) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			case (e[25:24])
				2'h0: chk("accum", e[23:0], {15'h0, accum_o, status_o.null_res});
				2'h1: chk("file", e[23:0], {7'h0, file_wr_o, status_o.null_res});
				2'h2: chk("call", e[23:0], {10'h0, busy_o, pc_o});
				default: chk("kick", e[23:0], {5'h0, watchdog_counter_o, wdt_prescaler_o,
					status_o});
			endcase
		end
	end
	initial begin
		logic [6:0] a;
		logic [7:0] m, r, l;
		logic [10:0] k;
		{nrst_i, instr_valid_i, sleeping_i, irq_wake_i, wdt_wake_i, global_irq_enable_i} = '0;
		instr_i = 14'h0000;
		pc_upper_latch_i = 8'h00;
		for (int i = 0; i < 128; i++) iex_fmem_inst.mem[i] = xs();
		iex_fmem_inst.mem[5] = 8'hff;
		iex_fmem_inst.mem[6] = 8'h01;
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		go(iex_pkg::OP_ACLR, {2'h0, 15'h0, 8'h00, 1'b1});
		for (int i = 0; i < 8; i++) begin
			repeat (2) @(negedge sys_clk_i);
			a = (i < 2) ? 7'(5 + i) : 7'(xs());
			m = iex_fmem_inst.mem[a];
			r = i[0] ? m - 8'h01 : ~m;
			if (i[1]) go({i[0] ? iex_pkg::OP_FDEC : iex_pkg::OP_FINV, 1'b1, a},
				{2'h1, 7'h0, 1'b1, a, r, r == 8'h00});
			else go({i[0] ? iex_pkg::OP_FDEC : iex_pkg::OP_FINV, 1'b0, a},
				{2'h0, 15'h0, r, r == 8'h00});
		end
		a = 7'(xs());
		go({iex_pkg::OP_FCLR, a}, {2'h1, 7'h0, 1'b1, a, 8'h00, 1'b1});
		$display("file ops done");
		for (int i = 0; i < 2; i++) begin
			l = xs();
			k = 11'({xs(), xs()});
			pc_upper_latch_i <= l;
			go({iex_pkg::OP_CALL, k}, {2'h2, 10'h0, 1'b1, l[4:3], k});
		end
		go(iex_pkg::OP_KICK, {2'h3, 5'h0, 16'h0000, 3'b111});
		$display("call and kick done");
		@(posedge sys_clk_i);
		sleeping_i <= 1'b1;
		global_irq_enable_i <= 1'b1;
		irq_wake_i <= 1'b1;
		repeat (3) @(negedge sys_clk_i);
		chk("wake", {10'h0, 1'b1, 13'h0004}, {10'h0, wake_irq_flag_o, pc_o});
		@(posedge sys_clk_i);
		wdt_wake_i <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk("wdt wake", 24'h000001, {23'h0, wake_wdt_flag_o});
		$display("wake done");
		close_out();
	end
endmodule
`default_nettype wire
